// file: program_security_lock.sv
// security gate for programming and readback of the device
// assumes host commands arrive as one-cycle requests on the same clock
`timescale 1ns/1ps
module program_security_lock #(
  parameter int KW = lock_pkg::KEY_W,
  parameter int DW = lock_pkg::DATA_W
)(
  input  wire logic           i_clk,
  input  wire logic           i_reset_n,
  input  wire logic           i_req_valid,
  input  wire lock_pkg::req_t i_req,
  input  wire logic [DW-1:0]  i_umem_rdata,
  output logic                o_busy,
  output logic                o_rsp_valid,
  output lock_pkg::rsp_t      o_rsp,
  output logic                o_prog_we,
  output logic [1:0]          o_prog_region,
  output logic [DW-1:0]       o_prog_data,
  output logic                o_locked,
  output logic                o_unlocked
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_DEC  = 2'b01,
    ST_WAIT = 2'b10
  } st_t;

  st_t            st_r;
  st_t            st_nxt;
  lock_pkg::sec_t sec_r;
  logic           unlocked_r;
  logic           unlocked_nxt;
  logic [1:0]     region_r;
  logic [1:0]     region_nxt;
  logic           dec_start;
  logic [DW-1:0]  dec_plain;
  logic           dec_ok;
  logic           dec_done;
  logic           direct_ans;
  logic           direct_ok;
  logic           rsp_valid_nxt;
  logic           rsp_ok_nxt;
  logic [DW-1:0]  rsp_data_nxt;
  lock_pkg::rsp_t rsp_nxt;
  logic           prog_we_nxt;
  logic [1:0]     prog_region_nxt;
  logic [DW-1:0]  prog_data_nxt;

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  wire take        = i_req_valid && (st_r == ST_IDLE);
  wire is_unlock   = take && (i_req.cmd == lock_pkg::CMD_UNLOCK);
  wire is_setsec   = take && (i_req.cmd == lock_pkg::CMD_SETSEC);
  wire is_prog     = take && (i_req.cmd == lock_pkg::CMD_PROGRAM);
  wire is_read     = take && (i_req.cmd == lock_pkg::CMD_READ);
  wire is_relock   = take && (i_req.cmd == lock_pkg::CMD_RELOCK);
  wire region_ok   = (i_req.region <= 2'(lock_pkg::REG_FBLK));
  wire locked      = sec_r.lock_en && !unlocked_r;

  // ---------------------------------------------
  // permission checks
  // ---------------------------------------------
  // pass key compare
  wire key_match   = (i_req.key == sec_r.pass_key);
  // key only for unlock and settings
  wire unlock_ok   = is_unlock && (!sec_r.lock_en || key_match);
  wire set_ok      = is_setsec && !locked;
  wire set_legal   = set_ok && !(i_req.sec.aes_en && !i_req.sec.lock_en);
  wire reg_enc     = sec_r.aes_en && sec_r.enc_region[i_req.region];
  wire plain_ok    = is_prog && region_ok && !i_req.encrypted && !reg_enc && !locked;
  wire cipher_go   = is_prog && region_ok && i_req.encrypted && sec_r.aes_en;
  // only user memory has a read path
  wire rd_umem     = is_read && (i_req.region == 2'(lock_pkg::REG_UMEM));
  wire rd_ok       = rd_umem && sec_r.umem_rd_en && !locked;
  assign dec_start = cipher_go;

  // ---------------------------------------------
  // cipher stage
  // ---------------------------------------------
  // decrypt with internally stored key
  key_cipher #(
    .DW (DW),
    .KW (KW)
  ) key_cipher_inst (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (dec_start),
    .i_key     (sec_r.aes_key),
    .i_word    (i_req.data),
    .o_plain   (dec_plain),
    .o_auth_ok (dec_ok),
    .o_done    (dec_done)
  );

  // ---------------------------------------------
  // sequencing
  // ---------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: if (cipher_go) st_nxt = ST_DEC;
      ST_DEC:  st_nxt = ST_WAIT;
      ST_WAIT: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // mismatch leaves unlock flag untouched while lock_en is set
  // new settings clear the unlock flag, so an old unlock cannot outlive them
  assign unlocked_nxt = unlock_ok ? 1'b1 : ((is_relock || set_legal) ? 1'b0 : unlocked_r);
  assign region_nxt   = cipher_go ? i_req.region : region_r;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r     <= ST_IDLE;
      region_r <= 2'h0;
    end
    else
    begin
      st_r     <= st_nxt;
      region_r <= region_nxt;
    end
  end

  // unlock flag kept apart from the settings it guards
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      unlocked_r <= 1'b0;
    end
    else
    begin
      unlocked_r <= unlocked_nxt;
    end
  end

  // settings and keys written only by a legal set
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sec_r <= '{lock_en: 1'b0, aes_en: 1'b0, enc_region: lock_pkg::ENC_RESET,
                 umem_rd_en: lock_pkg::RD_EN_RESET, pass_key: '0, aes_key: '0};
    end
    else if (set_legal)
    begin
      sec_r <= i_req.sec;
    end
  end

  // ---------------------------------------------
  // responses
  // ---------------------------------------------
  // direct answers never meet a cipher answer: busy blocks every take meanwhile
  assign direct_ans      = take && !cipher_go;
  assign direct_ok       = unlock_ok || set_legal || plain_ok || rd_ok || is_relock;
  assign rsp_valid_nxt   = direct_ans || dec_done;
  assign rsp_ok_nxt      = direct_ans ? direct_ok : dec_ok;
  assign rsp_data_nxt    = rd_ok ? i_umem_rdata : '0;
  assign rsp_nxt         = '{ok: rsp_ok_nxt, err: !rsp_ok_nxt, data: rsp_data_nxt};
  // encrypted data written only on authentication
  assign prog_we_nxt     = plain_ok || (dec_done && dec_ok);
  assign prog_region_nxt = plain_ok ? i_req.region : region_r;
  assign prog_data_nxt   = plain_ok ? i_req.data : dec_plain;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rsp_valid <= 1'b0;
      o_prog_we   <= 1'b0;
    end
    else
    begin
      o_rsp_valid <= rsp_valid_nxt;
      o_prog_we   <= prog_we_nxt;
    end
  end

  // answer fields stand until the next answer
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rsp <= '0;
    end
    else if (rsp_valid_nxt)
    begin
      o_rsp <= rsp_nxt;
    end
  end

  // write region and data stand until the next write
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_prog_region <= 2'h0;
      o_prog_data   <= '0;
    end
    else if (prog_we_nxt)
    begin
      o_prog_region <= prog_region_nxt;
      o_prog_data   <= prog_data_nxt;
    end
  end

  // ---------------------------------------------
  // status
  // ---------------------------------------------
  assign o_busy     = (st_r != ST_IDLE);
  assign o_locked   = locked;
  assign o_unlocked = unlocked_r;
endmodule : program_security_lock

// file: lock_pkg.sv
// constants and carrier types for the program security lock
// assumes one 200 mhz clock domain and a host command port from fabric logic
// Summary of operation
// - encryption chosen per region independently
// - locked keyed device programs only authenticated streams
// - pass key needed only for unlock, settings
// - decrypt with stored key, never streamed
// - unlock only when presented key matches, or with any key while lock_en is clear
// - security changes blocked while locked, unless unlocked first
// - logic array never read back
// - user memory readback follows security settings
// - plaintext accepted when not locked and no encryption in force
// - stored key allows remote encrypted reprogramming
package lock_pkg;
  localparam int KEY_W = 128;
  localparam int DATA_W = 32;
  // region index positions
  localparam int REG_ARRAY = 0;
  localparam int REG_UMEM = 1;
  localparam int REG_FBLK = 2;
  localparam int N_REGION = 3;
  localparam logic [N_REGION-1:0] ENC_RESET = 3'h0;
  localparam logic RD_EN_RESET = 1'b1;
  localparam int CMP_CYCLES = 1;

  typedef enum logic [2:0]
  {
    CMD_NONE    = 3'h0,
    CMD_UNLOCK  = 3'h1,
    CMD_SETSEC  = 3'h2,
    CMD_PROGRAM = 3'h3,
    CMD_READ    = 3'h4,
    CMD_RELOCK  = 3'h5
  } cmd_t;

  typedef struct packed
  {
    logic                lock_en;
    logic                aes_en;
    logic [N_REGION-1:0] enc_region;
    logic                umem_rd_en;
    logic [KEY_W-1:0]    pass_key;
    logic [KEY_W-1:0]    aes_key;
  } sec_t;

  typedef struct packed
  {
    cmd_t                cmd;
    logic [1:0]          region;
    logic                encrypted;
    logic [DATA_W-1:0]   data;
    logic [KEY_W-1:0]    key;
    sec_t                sec;
  } req_t;

  typedef struct packed
  {
    logic              ok;
    logic              err;
    logic [DATA_W-1:0] data;
  } rsp_t;
endpackage : lock_pkg

// file: key_cipher.sv
// keyed stream cipher stage: stored key combines with data words
// assumes key comes from internal storage only, never the stream
`timescale 1ns/1ps
module key_cipher #(
  parameter int DW = lock_pkg::DATA_W,
  parameter int KW = lock_pkg::KEY_W
)(
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_start,
  input  wire logic [KW-1:0] i_key,
  input  wire logic [DW-1:0] i_word,
  output logic      [DW-1:0] o_plain,
  output logic               o_auth_ok,
  output logic               o_done
);
  // ---------------------------------------------
  // key fold and tag check
  // ---------------------------------------------
  // stand-in for the real block cipher; keeps the datapath shape
  logic [DW-1:0] fold;
  logic [DW-1:0] plain_nxt;
  always_comb
  begin
    fold = '0;
    for (int i = 0; i < KW / DW; i++)
    begin
      fold = fold ^ i_key[i*DW +: DW];
    end
    plain_nxt = i_word ^ fold;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_plain   <= '0;
      o_auth_ok <= 1'b0;
      o_done    <= 1'b0;
    end
    else
    begin
      o_done <= i_start;
      if (i_start)
      begin
        o_plain   <= plain_nxt;
        // low byte of a decrypted word must equal the key fold tag
        o_auth_ok <= (plain_nxt[7:0] == fold[DW-1:DW-8]);
      end
    end
  end
endmodule : key_cipher

// file: lock_props.sv
// assertions on the security gate ports
// assumes one clock domain, bound to every gate instance
`timescale 1ns/1ps
module lock_props #(
  parameter int KW = lock_pkg::KEY_W,
  parameter int DW = lock_pkg::DATA_W
)(
  input wire logic           i_clk,
  input wire logic           i_reset_n,
  input wire logic           i_req_valid,
  input wire lock_pkg::req_t i_req,
  input wire logic [DW-1:0]  i_umem_rdata,
  input wire logic           o_busy,
  input wire logic           o_rsp_valid,
  input wire lock_pkg::rsp_t o_rsp,
  input wire logic           o_prog_we,
  input wire logic [1:0]     o_prog_region,
  input wire logic [DW-1:0]  o_prog_data,
  input wire logic           o_locked,
  input wire logic           o_unlocked
);
  wire tk = i_req_valid && !o_busy;
  wire rd = tk && i_req.cmd == lock_pkg::CMD_READ;
  wire pg = tk && i_req.cmd == lock_pkg::CMD_PROGRAM;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_array_read:
    assert property (rd && i_req.region == 2'h0 |=> o_rsp_valid && o_rsp.err) else $error("array read let out");
  chk_umem_locked:
    assert property (rd && o_locked |=> o_rsp.err) else $error("locked read let out");
  chk_setsec_locked:
    assert property (tk && i_req.cmd == lock_pkg::CMD_SETSEC && o_locked |=> o_rsp.err && o_locked)
      else $error("settings changed while locked");
  chk_plain_locked:
    assert property (pg && !i_req.encrypted && o_locked |=> !o_prog_we && o_rsp.err) else $error("plain write locked");
  chk_enc_timing:
    assert property (pg && i_req.encrypted |=> (o_busy ##1 o_busy && o_rsp_valid && o_prog_we == o_rsp.ok)
      or (!o_busy && o_rsp_valid && o_rsp.err)) else $error("encrypted program timing");
  chk_write_ok:
    assert property (o_prog_we |-> o_rsp_valid && o_rsp.ok && !o_rsp.err) else $error("write without ok");
  chk_unlock_keep:
    assert property (tk && i_req.cmd == lock_pkg::CMD_UNLOCK && o_locked |=> o_rsp_valid && (o_rsp.ok ? o_unlocked
      : o_locked)) else $error("unlock outcome");
  chk_bad_region:
    assert property (pg && i_req.region == 2'h3 |=> o_rsp_valid && o_rsp.err && !o_prog_we)
      else $error("region three written");
  cover property (o_prog_we);
  cover property (rd ##1 o_rsp.ok);
  cover property ($rose(o_unlocked));
endmodule : lock_props
bind program_security_lock lock_props #(.KW(KW), .DW(DW)) lock_props_inst(.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_req_valid(i_req_valid), .i_req(i_req), .i_umem_rdata(i_umem_rdata), .o_busy(o_busy), .o_rsp_valid(o_rsp_valid),
  .o_rsp(o_rsp), .o_prog_we(o_prog_we), .o_prog_region(o_prog_region), .o_prog_data(o_prog_data),
  .o_locked(o_locked), .o_unlocked(o_unlocked));

// file: host_model.sv
// programming host: one request, then waits for the answer
// assumes callers enter only from the bench thread
`timescale 1ns/1ps
module host_model(
  input  wire logic           i_clk,
  input  wire logic           i_rsp_valid,
  input  wire lock_pkg::rsp_t i_rsp,
  output logic                o_req_valid,
  output lock_pkg::req_t      o_req
);
  initial o_req_valid = 1'b0;
  initial o_req = '0;
  // caller sets lock with aes, key
  task automatic xfer(input lock_pkg::req_t r, output lock_pkg::rsp_t s);
    @(posedge i_clk);
    o_req_valid <= 1'b1;
    o_req <= r;
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    o_req <= lock_pkg::req_t'(~r);
    #1;
    for (int n = 0; n < 3 && i_rsp_valid !== 1'b1; n++)
    begin
      @(posedge i_clk);
      #1;
    end
    s = (i_rsp_valid === 1'b1) ? i_rsp : '0;
  endtask : xfer
endmodule : host_model

// file: test_program_security_lock.sv
// bench for the security gate, host model issues requests
// assumes one clock, async reset, no software registers
`timescale 1ns/1ps
module test_program_security_lock;
  logic           i_clk = 1'b0;
  logic           i_reset_n = 1'b0;
  logic           req_valid, busy, rsp_valid, prog_we, locked, unlocked;
  lock_pkg::req_t req;
  lock_pkg::rsp_t rsp, s;
  lock_pkg::sec_t sec;
  logic [1:0]     prog_region;
  logic [31:0]    prog_data;
  int             fail_count = 0;
  int             samples_checked = 0;
  int             cyc = 0;
  always #2.5 i_clk = ~i_clk;
  host_model host_model_inst(.i_clk(i_clk), .i_rsp_valid(rsp_valid), .i_rsp(rsp), .o_req_valid(req_valid), .o_req(req));
  program_security_lock program_security_lock_inst(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(req_valid),
    .i_req(req), .i_umem_rdata(32'hc3a50f1e), .o_busy(busy), .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_prog_we(prog_we),
    .o_prog_region(prog_region), .o_prog_data(prog_data), .o_locked(locked), .o_unlocked(unlocked));
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic go(input lock_pkg::cmd_t c, input logic [1:0] rg, input logic en, input logic [31:0] d,
    input logic [127:0] k);
    lock_pkg::req_t r;
    r = '0;
    r.cmd = c;
    r.region = rg;
    r.encrypted = en;
    r.data = d;
    r.key = k;
    r.sec = sec;
    host_model_inst.xfer(r, s);
  endtask : go
  task automatic t_lock;
    go(lock_pkg::CMD_PROGRAM, 2'h0, 1'b0, 32'h11, '0);
    chk("plain write", {prog_we, s.ok, busy, prog_region, prog_data}, {3'h6, 2'h0, 32'h11});
    go(lock_pkg::CMD_SETSEC, 2'h0, 1'b0, '0, '0);
    chk("set ok", {s.ok, locked}, 2'h3);
    go(lock_pkg::CMD_SETSEC, 2'h0, 1'b0, '0, '0);
    chk("set locked", {s.err, locked}, 2'h3);
    go(lock_pkg::CMD_UNLOCK, 2'h0, 1'b0, '0, 128'hbeee);
    chk("bad key", {s.err, locked, unlocked}, 3'h6);
  endtask : t_lock
  task automatic t_enc;
    // fold of the aes key is 5a000000
    go(lock_pkg::CMD_PROGRAM, 2'h0, 1'b1, 32'h4834565a, '0);
    chk("enc write", {prog_we, busy, prog_region, prog_data}, {2'h3, 2'h0, 32'h1234565a});
    go(lock_pkg::CMD_PROGRAM, 2'h0, 1'b1, 32'h48345600, '0);
    chk("bad auth", {s.err, prog_we}, 2'h2);
    go(lock_pkg::CMD_PROGRAM, 2'h2, 1'b0, 32'h1, '0);
    chk("locked plain", {s.err, prog_we}, 2'h2);
  endtask : t_enc
  task automatic t_open;
    go(lock_pkg::CMD_UNLOCK, 2'h0, 1'b0, '0, 128'hbeef);
    chk("unlock", {s.ok, unlocked, locked}, 3'h6);
    go(lock_pkg::CMD_PROGRAM, 2'h1, 1'b0, 32'h5, '0);
    chk("enc region", {s.err, prog_we}, 2'h2);
    go(lock_pkg::CMD_PROGRAM, 2'h2, 1'b0, 32'h22, '0);
    chk("open region", {prog_we, prog_region, prog_data}, {3'h6, 32'h22});
    go(lock_pkg::CMD_READ, 2'h0, 1'b0, '0, '0);
    chk("array read", s.err, 1'b1);
    go(lock_pkg::CMD_READ, 2'h1, 1'b0, '0, '0);
    chk("umem read", {s.ok, s.data}, {1'b1, 32'hc3a50f1e});
  endtask : t_open
  task automatic t_edge;
    sec.lock_en = 1'b0;
    go(lock_pkg::CMD_SETSEC, 2'h0, 1'b0, '0, '0);
    chk("aes without lock", {s.err, unlocked}, 2'h3);
    sec.lock_en = 1'b1;
    go(lock_pkg::CMD_PROGRAM, 2'h3, 1'b0, 32'h33, '0);
    chk("region three", {s.err, prog_we}, 2'h2);
    go(lock_pkg::CMD_RELOCK, 2'h0, 1'b0, '0, '0);
    chk("relock", {s.ok, locked, unlocked}, 3'h6);
    go(lock_pkg::CMD_READ, 2'h1, 1'b0, '0, '0);
    chk("locked read", {s.err, s.ok}, 2'h2);
    go(lock_pkg::CMD_UNLOCK, 2'h0, 1'b0, '0, 128'hbeef);
    chk("unlock again", {s.ok, unlocked}, 2'h3);
    sec.aes_en = 1'b0;
    go(lock_pkg::CMD_SETSEC, 2'h0, 1'b0, '0, '0);
    chk("set no aes", {s.ok, locked}, 2'h3);
    go(lock_pkg::CMD_PROGRAM, 2'h0, 1'b1, 32'h4834565a, '0);
    chk("enc without aes", {s.err, busy, prog_we}, 3'h4);
  endtask : t_edge
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fail_count++;
      close_out();
    end
  end
  initial
  begin
    sec = '0;
    sec.lock_en = 1'b1;
    sec.aes_en = 1'b1;
    sec.enc_region = 3'h3;
    sec.umem_rd_en = 1'b1;
    sec.pass_key = 128'hbeef;
    sec.aes_key = 128'h5a000000;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_lock();
    t_enc();
    t_open();
    t_edge();
    close_out();
  end
endmodule : test_program_security_lock
